// ===== src/rbpr_top.sv
/*
 RAM bank power and retention control registers with AXI4-Lite access.
 Assumes one clock aclk at 100 MHz and a synchronous active-low reset;
 system_off comes from the power manager, synchronous to aclk.
*/
`timescale 1ns/1ps

// Operation
// - Bits 0 to 15 of the control register are the section power bits, 1 on and 0 off.
// - Bits 16 to 31 of the control register are the section retention bits, 1 keeps contents when off.
// - A powered section always keeps its contents whatever its retention bit.
// - An unpowered section keeps its contents only when its retention bit is set.
// - In system off every section is switched off regardless of its power bit.
// - Writing 1 in bits 0 to 15 of the set register at 0x954 turns on that section's power bit.
// - The control register sits at 0x950 and is readable and writable.
// - Writing 1 to a bit of the clear register at 0x958 clears that control bit.
module rbpr_top
    import rbpr_pkg::*;
#(
    parameter int SECTIONS = RBPR_SECTIONS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [RBPR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [RBPR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power manager
    input wire logic system_off,
    // Section drive
    output logic [SECTIONS-1:0] section_supply_en,
    output logic [SECTIONS-1:0] section_retain
);
    logic wr_en;
    logic [RBPR_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [RBPR_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [31:0] control;
    logic [31:0] next_control;
    logic [31:0] byte_mask;

    // ----------------------------------------
    // Bus front end
    // ----------------------------------------
    rbpr_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    assign byte_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wr_ok = (wr_addr == RBPR_OFF_CONTROL) || (wr_addr == RBPR_OFF_SET) || (wr_addr == RBPR_OFF_CLEAR);
    // Set and clear are write-only; they read as zero
    assign rd_ok = (rd_addr == RBPR_OFF_CONTROL) || (rd_addr == RBPR_OFF_SET) || (rd_addr == RBPR_OFF_CLEAR);
    assign rd_data = (rd_addr == RBPR_OFF_CONTROL) ? control : 32'h00000000;

    always_comb begin
        next_control = control;
        if (wr_en) begin
            if (wr_addr == RBPR_OFF_CONTROL) begin
                // Power low half, keep-contents high half
                next_control = (control & ~byte_mask) | (wr_data & byte_mask);
            end else if (wr_addr == RBPR_OFF_SET) begin
                // Only ones act, and only on power bits
                next_control = control | (wr_data & byte_mask & RBPR_SET_MASK);
            end else if (wr_addr == RBPR_OFF_CLEAR) begin
                next_control = control & ~(wr_data & byte_mask);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= RBPR_CONTROL_RESET;
        end else begin
            control <= next_control;
        end
    end

    // ----------------------------------------
    // Section drive
    // ----------------------------------------
    rbpr_section_ctrl #(
        .SECTIONS(SECTIONS)
    ) u_sec (
        .section_power_on(control[RBPR_POWER_LSB +: SECTIONS]),
        .section_keep_contents(control[RBPR_KEEP_LSB +: SECTIONS]),
        .system_off(system_off),
        .section_supply_en(section_supply_en),
        .section_retain(section_retain)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_full_write(logic [11:0] off);
        wr_en && wr_addr == off && wr_strb == 4'hf;
    endsequence

    property p_ctrl_write;
        @(posedge aclk) disable iff (!aresetn)
        s_full_write(RBPR_OFF_CONTROL) |=> control == $past(wr_data);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

    property p_keep_half;
        @(posedge aclk) disable iff (!aresetn)
        s_full_write(RBPR_OFF_CONTROL) |=> control[31:16] == $past(wr_data[31:16]);
    endproperty
    a_keep_half: assert property (p_keep_half) else $error("keep bits not stored");

    property p_powered_retain;
        @(posedge aclk) disable iff (!aresetn)
        !system_off |-> (section_retain & control[15:0]) == control[15:0];
    endproperty
    a_powered_retain: assert property (p_powered_retain) else $error("powered section lost");

    property p_off_retain;
        @(posedge aclk) disable iff (!aresetn)
        system_off |-> section_retain == control[31:16];
    endproperty
    a_off_retain: assert property (p_off_retain) else $error("retain wrong when off");

    property p_sys_off;
        @(posedge aclk) disable iff (!aresetn)
        system_off |-> section_supply_en == 16'h0000;
    endproperty
    a_sys_off: assert property (p_sys_off) else $error("section on in system off");

    property p_set;
        @(posedge aclk) disable iff (!aresetn)
        s_full_write(RBPR_OFF_SET) |=> control == ($past(control) | ($past(wr_data) & 32'h0000ffff));
    endproperty
    a_set: assert property (p_set) else $error("set write wrong");

    property p_set_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_full_write(RBPR_OFF_SET) |=> (control & ~$past(wr_data)) == ($past(control) & ~$past(wr_data));
    endproperty
    a_set_zero: assert property (p_set_zero) else $error("set zero changed bit");

    property p_clear;
        @(posedge aclk) disable iff (!aresetn)
        s_full_write(RBPR_OFF_CLEAR) |=> control == ($past(control) & ~$past(wr_data));
    endproperty
    a_clear: assert property (p_clear) else $error("clear write wrong");

    property p_read;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == RBPR_OFF_CONTROL |=> s_axi_rvalid && s_axi_rdata == $past(control);
    endproperty
    a_read: assert property (p_read) else $error("control read wrong");

    // ----------------------------------------
    // Bus handshake and side-effect checks
    // ----------------------------------------
    sequence s_read_take(logic [11:0] off);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == off;
    endsequence

    // A pending response blocks new AW and W, so one write is in flight
    property p_aw_refused;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_refused: assert property (p_aw_refused) else $error("write taken while response pending");

    property p_ar_refused;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refused: assert property (p_ar_refused) else $error("read taken while data pending");

    property p_wr_en_once;
        @(posedge aclk) disable iff (!aresetn)
        wr_en |=> !wr_en;
    endproperty
    a_wr_en_once: assert property (p_wr_en_once) else $error("write applied twice");

    property p_write_okay;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_ok |=> s_axi_bvalid && s_axi_bresp == RBPR_RESP_OKAY;
    endproperty
    a_write_okay: assert property (p_write_okay) else $error("mapped write not okay");

    property p_write_slverr;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && !wr_ok |=> s_axi_bvalid && s_axi_bresp == RBPR_RESP_SLVERR;
    endproperty
    a_write_slverr: assert property (p_write_slverr) else $error("unmapped write not refused");

    property p_bvalid_drop;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bvalid_drop: assert property (p_bvalid_drop) else $error("write response repeated");

    property p_rvalid_drop;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_rvalid_drop: assert property (p_rvalid_drop) else $error("read data repeated");

    property p_unmapped_stable;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && !wr_ok |=> control == $past(control);
    endproperty
    a_unmapped_stable: assert property (p_unmapped_stable) else $error("unmapped write changed control");

    property p_idle_stable;
        @(posedge aclk) disable iff (!aresetn)
        !wr_en |=> control == $past(control);
    endproperty
    a_idle_stable: assert property (p_idle_stable) else $error("control changed without write");

    property p_read_unmapped;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && !rd_ok |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == RBPR_RESP_SLVERR;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not refused");

    // Set is write-only, so software must never see stale bits there
    property p_read_set;
        @(posedge aclk) disable iff (!aresetn)
        s_read_take(RBPR_OFF_SET) |=> s_axi_rvalid && s_axi_rdata == 32'h00000000 && s_axi_rresp == RBPR_RESP_OKAY;
    endproperty
    a_read_set: assert property (p_read_set) else $error("set register read not zero");

    property p_set_keep_untouched;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_addr == RBPR_OFF_SET |=> control[31:16] == $past(control[31:16]);
    endproperty
    a_set_keep_untouched: assert property (p_set_keep_untouched) else $error("set touched keep bits");

    property p_set_only_up;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_addr == RBPR_OFF_SET |=> ($past(control) & ~control) == 32'h00000000;
    endproperty
    a_set_only_up: assert property (p_set_only_up) else $error("set cleared a bit");

    property p_clear_only_down;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_addr == RBPR_OFF_CLEAR |=> (control & ~$past(control)) == 32'h00000000;
    endproperty
    a_clear_only_down: assert property (p_clear_only_down) else $error("clear set a bit");

    property p_supply_follows;
        @(posedge aclk) disable iff (!aresetn)
        !system_off |-> section_supply_en == control[RBPR_POWER_LSB +: SECTIONS];
    endproperty
    a_supply_follows: assert property (p_supply_follows) else $error("supply differs from power bits");

    property p_retain_keep;
        @(posedge aclk) disable iff (!aresetn)
        (section_retain & control[RBPR_KEEP_LSB +: SECTIONS]) == control[RBPR_KEEP_LSB +: SECTIONS];
    endproperty
    a_retain_keep: assert property (p_retain_keep) else $error("keep bit set but not retained");

    property p_unpowered_lost;
        @(posedge aclk) disable iff (!aresetn)
        (section_retain & ~section_supply_en & ~control[RBPR_KEEP_LSB +: SECTIONS]) == '0;
    endproperty
    a_unpowered_lost: assert property (p_unpowered_lost) else $error("unpowered section retained");

    property p_reset_value;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> control == RBPR_CONTROL_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("control not at reset value");
endmodule

// ===== src/rbpr_pkg.sv
/*
 Shared constants for the RAM bank power and retention register block.
 Assumes a 32-bit AXI4-Lite register bus with word-aligned accesses.
*/
package rbpr_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int RBPR_SECTIONS = 16;
    localparam int RBPR_ADDR_W = 12;
    localparam int RBPR_DATA_W = 32;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [11:0] RBPR_OFF_CONTROL = 12'h950;
    localparam logic [11:0] RBPR_OFF_SET = 12'h954;
    localparam logic [11:0] RBPR_OFF_CLEAR = 12'h958;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int RBPR_POWER_LSB = 0;
    localparam int RBPR_KEEP_LSB = 16;
    localparam logic [31:0] RBPR_CONTROL_RESET = 32'h0000ffff;
    localparam logic [31:0] RBPR_SET_MASK = 32'h0000ffff;
    // ----------------------------------------
    // AXI responses
    // ----------------------------------------
    localparam logic [1:0] RBPR_RESP_OKAY = 2'h0;
    localparam logic [1:0] RBPR_RESP_SLVERR = 2'h2;
endpackage

// ===== src/rbpr_axil_slave.sv
/*
 AXI4-Lite slave front end: captures one write and one read at a time and
 hands single-cycle strobes to the register file.
 Assumes the register file answers reads combinationally.
*/
`timescale 1ns/1ps
module rbpr_axil_slave
    import rbpr_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [RBPR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read
    input wire logic [RBPR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register file side
    output logic wr_en,
    output logic [RBPR_ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [RBPR_ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_held;
    logic w_held;

    // ----------------------------------------
    // Write path
    // ----------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_en = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            wr_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (wr_en) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RBPR_RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RBPR_RESP_OKAY : RBPR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RBPR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_data : 32'h00000000;
            s_axi_rresp <= rd_ok ? RBPR_RESP_OKAY : RBPR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ===== src/rbpr_section_ctrl.sv
/*
 Per-section power gate and retention decision.
 Assumes the control bits come straight from the register file.
*/
`timescale 1ns/1ps
module rbpr_section_ctrl
    import rbpr_pkg::*;
#(
    parameter int SECTIONS = RBPR_SECTIONS
) (
    // Control
    input wire logic [SECTIONS-1:0] section_power_on,
    input wire logic [SECTIONS-1:0] section_keep_contents,
    input wire logic system_off,
    // Section drive
    output logic [SECTIONS-1:0] section_supply_en,
    output logic [SECTIONS-1:0] section_retain
);
    // ----------------------------------------
    // Per-section decision
    // ----------------------------------------
    for (genvar i = 0; i < SECTIONS; i++) begin : g_sec
        // System off overrides every power bit
        assign section_supply_en[i] = section_power_on[i] && !system_off;
        // Powered sections always hold; unpowered ones only with keep set
        assign section_retain[i] = section_supply_en[i] || section_keep_contents[i];
    end
endmodule

// ===== verif/tb_ram_bank_power_retention_regs.sv
/*
 Self-checking bench for the RAM bank power and retention register block.
 Assumes rbpr_top with its AXI4-Lite port, one 100 MHz clock and
 a synchronous active-low reset.
*/
`timescale 1ns/1ps
module tb_ram_bank_power_retention_regs
    import rbpr_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk;
    logic aresetn;
    logic [RBPR_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic system_off;
    logic [15:0] section_supply_en, section_retain;
    int err_count;
    int comparisons;
    logic [31:0] rd;
    logic [1:0] rsp;

    rbpr_top #(.SECTIONS(16)) rbpr_top_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .system_off(system_off),
        .section_supply_en(section_supply_en), .section_retain(section_retain)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t response got %h expected %h", $time, got, exp);
        end
    endtask

    // Sections are sampled mid-cycle, away from the launching edge
    task automatic chk_sec(input logic [15:0] sup, input logic [15:0] ret);
        @(negedge aclk);
        chk_val({16'h0000, section_supply_en}, {16'h0000, sup}, "supply");
        chk_val({16'h0000, section_retain}, {16'h0000, ret}, "retain");
    endtask

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] exp);
        int n;
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                chk_resp(s_axi_bresp, exp);
                done = 1'b1;
            end
        end
        if (!done) begin
            err_count++;
            $display("BAD t=%0t write timed out", $time);
            summarize();
        end
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic done;
        done = 1'b0;
        d = 32'h0;
        r = 2'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                done = 1'b1;
            end
        end
        if (!done) begin
            err_count++;
            $display("BAD t=%0t read timed out", $time);
            summarize();
        end
    endtask

    // Reads the control word and compares it with an OKAY answer
    task automatic chk_ctrl(input logic [31:0] exp);
        axi_read(RBPR_OFF_CONTROL, rd, rsp);
        chk_resp(rsp, RBPR_RESP_OKAY);
        chk_val(rd, exp, "control");
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        err_count = 0;
        comparisons = 0;
        aresetn = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        system_off = 1'b0;
        do_reset();
        chk_ctrl(RBPR_CONTROL_RESET);
        chk_sec(16'hffff, 16'hffff);
        $display("reset values done");
        // Mixed power and keep bits
        axi_write(RBPR_OFF_CONTROL, 32'h8001_0ff0, 4'hf, RBPR_RESP_OKAY);
        chk_ctrl(32'h8001_0ff0);
        chk_sec(16'h0ff0, 16'h8ff1);
        $display("control write done");
        // High bits of the set word are ignored, zeros change nothing
        axi_write(RBPR_OFF_SET, 32'hffff_0003, 4'hf, RBPR_RESP_OKAY);
        chk_ctrl(32'h8001_0ff3);
        axi_read(RBPR_OFF_SET, rd, rsp);
        chk_resp(rsp, RBPR_RESP_OKAY);
        chk_val(rd, 32'h0, "set readback");
        chk_sec(16'h0ff3, 16'h8ff3);
        $display("set register done");
        axi_write(RBPR_OFF_CLEAR, 32'h8000_0f00, 4'hf, RBPR_RESP_OKAY);
        chk_ctrl(32'h0001_00f3);
        chk_sec(16'h00f3, 16'h00f3);
        $display("clear register done");
        // System off overrides even freshly set power bits
        @(posedge aclk);
        system_off <= 1'b1;
        chk_sec(16'h0000, 16'h0001);
        axi_write(RBPR_OFF_SET, 32'h0000_ff00, 4'hf, RBPR_RESP_OKAY);
        chk_sec(16'h0000, 16'h0001);
        @(posedge aclk);
        system_off <= 1'b0;
        chk_sec(16'hfff3, 16'hfff3);
        $display("system off done");
        // Byte lanes and unmapped places
        axi_write(RBPR_OFF_CONTROL, 32'h1234_5678, 4'h3, RBPR_RESP_OKAY);
        chk_ctrl(32'h0001_5678);
        axi_write(12'h95c, 32'h0, 4'hf, RBPR_RESP_SLVERR);
        chk_ctrl(32'h0001_5678);
        axi_read(12'h900, rd, rsp);
        chk_resp(rsp, RBPR_RESP_SLVERR);
        chk_val(rd, 32'h0, "unmapped read");
        $display("strobes and unmapped done");
        // Second reset in mid-run
        do_reset();
        chk_ctrl(RBPR_CONTROL_RESET);
        chk_sec(16'hffff, 16'hffff);
        $display("second reset done");
        summarize();
    end
endmodule
